//--- logic/opmc_top.sv
/*
  opmc_top: operating mode controller with APB register access.
  Assumes cpu events are one-cycle pulses synchronous to pclk and that the
  debug command decoder presents one command per valid pulse.
*/
module opmc_top
  import opmc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_mode_select_pin,
  input  wire logic        wait_instr,
  input  wire logic        stop_instr,
  input  wire logic        debug_halt_instruction,
  input  wire logic        serial_debug_bkpt,
  input  wire logic        trace_bkpt,
  input  wire logic        irq_req,
  input  wire logic        wake_req,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  output logic             cmd_accept,
  output logic             cmd_reject,
  output logic             cmd_status_err,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             debug_clk_en,
  output logic             regulator_full,
  output logic             core_power_on,
  output logic             osc_run,
  output logic             converter_on,
  output logic             wake_timer_on,
  output logic             pin_latch,
  output logic             clear_int_mask,
  output logic             irq_stack_start,
  output logic             vector_fetch,
  output logic [15:0]      vector_addr,
  output logic             illegal_op_reset,
  output logic             por_restart
);

  ////////////////////////////////////////////////////////////////////////////
  opmc_mode_t  mode;
  opmc_mode_t  next_mode;
  logic [6:0]  ctrl;
  logic        ppd_select;
  logic        ppd_flag;
  logic        latch;
  logic        boot;
  logic        boot_pending;

  wire stop_permit      = ctrl[OPMC_B_STOP_PERMIT];
  wire debug_mode_permit = ctrl[OPMC_B_DBGEN];
  wire lowvolt_stop     = ctrl[OPMC_B_LOWVOLT_DETECT_ON] & ctrl[OPMC_B_LOWVOLT_IN_STOP_ON];

  wire cmd_halt   = cmd_valid && cmd_code == OPMC_CMD_HALT;
  wire cmd_memst  = cmd_code == OPMC_CMD_MEMST;
  wire cmd_nonint = cmd_code == OPMC_CMD_MEM || cmd_memst ||
                    cmd_code == OPMC_CMD_DREG || cmd_code == OPMC_CMD_HALT;
  wire cmd_active = cmd_code == OPMC_CMD_CPUREG || cmd_code == OPMC_CMD_TRACE ||
                    cmd_code == OPMC_CMD_RESUME;
  wire in_low     = mode == OPMC_WAIT || mode == OPMC_STOP3 || mode == OPMC_STOP2;

  // deep stop only when neither lvd nor debug needs the regulator
  wire want_deep  = ppd_select && !lowvolt_stop && !debug_mode_permit;

  ////////////////////////////////////////////////////////////////////////////
  // mode selection
  always_comb begin
    next_mode = mode;
    unique case (mode)
      OPMC_RUN: begin
        if (debug_halt_instruction || serial_debug_bkpt || trace_bkpt || cmd_halt)
          next_mode = OPMC_DEBUG;
        else if (wait_instr)
          next_mode = OPMC_WAIT;
        else if (stop_instr && stop_permit)
          next_mode = want_deep ? OPMC_STOP2 : OPMC_STOP3;
      end
      OPMC_DEBUG: begin
        if (cmd_valid && cmd_code == OPMC_CMD_RESUME)
          next_mode = OPMC_RUN;
      end
      OPMC_WAIT: begin
        if (cmd_halt)
          next_mode = OPMC_DEBUG;
        else if (irq_req)
          next_mode = OPMC_RUN;
      end
      OPMC_STOP3: begin
        if (cmd_halt && debug_mode_permit)
          next_mode = OPMC_DEBUG;
        else if (irq_req || wake_req)
          next_mode = OPMC_RUN;
      end
      OPMC_STOP2: begin
        if (irq_req || wake_req)
          next_mode = OPMC_RUN;
      end
    endcase
  end

  // boot: first cycle after reset decides run or debug from the mode pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode         <= OPMC_RUN;
      boot_pending <= 1'b1;
    end else begin
      boot_pending <= 1'b0;
      if (boot_pending)
        mode <= debug_mode_select_pin ? OPMC_RUN : OPMC_DEBUG;
      else
        mode <= next_mode;
    end
  end
  assign boot = boot_pending && debug_mode_select_pin;

  ////////////////////////////////////////////////////////////////////////////
  // registered event outputs
  wire stop2_wake = mode == OPMC_STOP2 && next_mode == OPMC_RUN;
  wire apb_wr     = psel && penable && pwrite;
  wire ppd_ack    = apb_wr && paddr == OPMC_PMC_ADDR && pwdata[OPMC_B_PARTIAL_POWERDOWN_ACK];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_int_mask   <= 1'b0;
      irq_stack_start  <= 1'b0;
      vector_fetch     <= 1'b0;
      vector_addr      <= 16'h0000;
      illegal_op_reset <= 1'b0;
      por_restart      <= 1'b0;
      cmd_accept       <= 1'b0;
      cmd_reject       <= 1'b0;
      cmd_status_err   <= 1'b0;
    end else begin
      clear_int_mask   <= mode == OPMC_RUN && next_mode == OPMC_WAIT && !boot_pending;
      irq_stack_start  <= mode == OPMC_WAIT && next_mode == OPMC_RUN;
      vector_fetch     <= boot || stop2_wake;
      vector_addr      <= OPMC_RESET_VEC;
      illegal_op_reset <= mode == OPMC_RUN && stop_instr && !stop_permit
                          && next_mode == OPMC_RUN;
      por_restart      <= stop2_wake;
      // command gating per mode
      cmd_accept       <= cmd_valid && ((mode == OPMC_RUN && cmd_nonint) ||
                          (mode == OPMC_DEBUG && (cmd_nonint || cmd_active)) ||
                          (in_low && cmd_code == OPMC_CMD_HALT) ||
                          (in_low && cmd_memst));
      cmd_reject       <= cmd_valid && ((mode == OPMC_RUN && cmd_active) ||
                          (in_low && !cmd_memst && cmd_code != OPMC_CMD_HALT));
      cmd_status_err   <= cmd_valid && in_low && cmd_memst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode control: flag and pin latch persist until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= OPMC_CTRL_RST;
      ppd_select <= 1'b0;
      ppd_flag   <= 1'b0;
      latch      <= 1'b0;
    end else begin
      if (apb_wr && paddr == OPMC_CTRL_ADDR)
        ctrl <= pwdata[6:0];
      if (apb_wr && paddr == OPMC_PMC_ADDR)
        ppd_select <= pwdata[OPMC_B_PARTIAL_POWERDOWN_SELECT];
      if (next_mode == OPMC_STOP2 && mode != OPMC_STOP2)
        latch <= 1'b1;
      else if (ppd_ack)
        latch <= 1'b0;
      // set wins over a simultaneous acknowledge
      if (stop2_wake)
        ppd_flag <= 1'b1;
      else if (ppd_ack)
        ppd_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and power gating from the mode state and control bits
  assign cpu_clk_en     = mode == OPMC_RUN;
  assign periph_clk_en  = mode == OPMC_RUN || mode == OPMC_DEBUG || mode == OPMC_WAIT;
  assign debug_clk_en   = !(mode == OPMC_STOP2) &&
                          !(mode == OPMC_STOP3 && !debug_mode_permit);
  assign regulator_full = periph_clk_en || (mode == OPMC_STOP3 &&
                          (debug_mode_permit || lowvolt_stop));
  assign core_power_on  = mode != OPMC_STOP2;
  assign osc_run        = periph_clk_en || (mode == OPMC_STOP3 &&
                          (ctrl[OPMC_B_OSCEN] || debug_mode_permit));
  assign converter_on   = periph_clk_en || (mode == OPMC_STOP3 && ctrl[OPMC_B_CONVON]);
  assign wake_timer_on  = ctrl[OPMC_B_WAKEON];
  assign pin_latch      = latch;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads zero with error
  wire hit_ctrl   = paddr == OPMC_CTRL_ADDR;
  wire hit_pmc    = paddr == OPMC_PMC_ADDR;
  wire hit_status = paddr == OPMC_STATUS_ADDR;
  wire [31:0] rd_mux = hit_ctrl   ? {25'h0, ctrl} :
                       hit_pmc    ? {29'h0, 1'b0, ppd_flag, ppd_select} :
                       hit_status ? {26'h0, latch, mode} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_pmc || hit_status);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule : opmc_top

//--- logic/opmc_pkg.sv
/*
  opmc_pkg: constants, register map and types for the operating mode controller.
  Assumes a 125 MHz APB clock and 32-bit aligned registers.
*/
// Summary of operation
// - mode pin high at reset release: run mode, fetch vector at 0xfffe:0xffff
// - enter debug on pin low, halt command, halt instruction or either breakpoint
// - in debug the cpu stays suspended awaiting debug commands
// - non-intrusive commands accepted in run and debug modes
// - cpu register access, trace and resume only in debug mode
// - wait stops cpu clock; system clocks and regulation keep running
// - entering wait clears the interrupt mask bit
// - interrupt during wait ends wait and starts interrupt stacking
// - in wait only halt and status memory commands accepted
// - status memory commands in wait or stop report error, no access
// - halt command in wait wakes into debug mode
// - stop instruction with stop permit enters a stop mode, clocks halted
// - stop instruction without stop permit forces illegal opcode reset
// - partial powerdown select 1 picks deep stop, 0 shallow stop
// - deep stop powers off cpu, peripherals, flash, clocks, converter
// - shallow stop keeps circuits in standby, ram and pins retained
// - only deep and shallow stop modes exist
// - oscillator may be kept running in shallow stop by configuration
// - low voltage detect active in stop forces shallow stop
// - debug permit set turns deep stop into shallow, debug stays clocked
// - deep stop wake restarts as power-on, pins latched, flag set
// - latch and flag persist until software writes 1 to acknowledge
package opmc_pkg;
  localparam logic [7:0]  OPMC_CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  OPMC_PMC_ADDR    = 8'h04;
  localparam logic [7:0]  OPMC_STATUS_ADDR = 8'h08;
  localparam logic [15:0] OPMC_RESET_VEC   = 16'hfffe;
  // control register bits
  localparam int OPMC_B_STOP_PERMIT  = 0;
  localparam int OPMC_B_DBGEN  = 1;
  localparam int OPMC_B_LOWVOLT_DETECT_ON   = 2;
  localparam int OPMC_B_LOWVOLT_IN_STOP_ON  = 3;
  localparam int OPMC_B_OSCEN  = 4;
  localparam int OPMC_B_CONVON = 5;
  localparam int OPMC_B_WAKEON = 6;
  // power mode control bits
  localparam int OPMC_B_PARTIAL_POWERDOWN_SELECT   = 0;
  localparam int OPMC_B_PARTIAL_POWERDOWN_FLAG   = 1;
  localparam int OPMC_B_PARTIAL_POWERDOWN_ACK = 2;
  localparam logic [6:0] OPMC_CTRL_RST = 7'h00;

  typedef enum logic [4:0] {
    OPMC_RUN   = 5'b00001,
    OPMC_DEBUG = 5'b00010,
    OPMC_WAIT  = 5'b00100,
    OPMC_STOP3 = 5'b01000,
    OPMC_STOP2 = 5'b10000
  } opmc_mode_t;

  typedef enum logic [2:0] {
    OPMC_CMD_MEM    = 3'h0,
    OPMC_CMD_MEMST  = 3'h1,
    OPMC_CMD_DREG   = 3'h2,
    OPMC_CMD_HALT   = 3'h3,
    OPMC_CMD_CPUREG = 3'h4,
    OPMC_CMD_TRACE  = 3'h5,
    OPMC_CMD_RESUME = 3'h6
  } opmc_cmd_t;
endpackage : opmc_pkg

//--- tb/opmc_checker.sv
/* opmc_checker: port assertions for opmc_top.
   Assumes one pclk domain and a bind onto every opmc_top. */
module opmc_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       debug_mode_select_pin,
  input wire logic       wait_instr,
  input wire logic       stop_instr,
  input wire logic       irq_req,
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic       cmd_accept,
  input wire logic       cmd_reject,
  input wire logic       cmd_status_err,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       debug_clk_en,
  input wire logic       regulator_full,
  input wire logic       core_power_on,
  input wire logic       converter_on,
  input wire logic       pin_latch,
  input wire logic       clear_int_mask,
  input wire logic       irq_stack_start,
  input wire logic       vector_fetch,
  input wire logic       illegal_op_reset,
  input wire logic       por_restart
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait_in;
    wait_instr && cpu_clk_en ##1 clear_int_mask;
  endsequence
  property p_vec;
    $rose(presetn) && debug_mode_select_pin |-> ##[0:2] vector_fetch;
  endproperty
  property p_nonint;
    cmd_valid && cmd_code < 3'h4 && cpu_clk_en |=> cmd_accept;
  endproperty
  property p_actv;
    cmd_valid && cmd_code > 3'h3 && cpu_clk_en |=> cmd_reject && !cmd_accept;
  endproperty
  property p_wait;
    wait_instr && cpu_clk_en |=> !cpu_clk_en && periph_clk_en && regulator_full;
  endproperty
  property p_irq;
    s_wait_in ##1 irq_req |=> irq_stack_start;
  endproperty
  property p_waitcmd;
    s_wait_in ##0 (cmd_valid && cmd_code == 3'h0) |=> cmd_reject;
  endproperty
  property p_stat;
    s_wait_in ##0 (cmd_valid && cmd_code == 3'h1) |=> cmd_status_err;
  endproperty
  property p_stop;
    stop_instr && cpu_clk_en |=> illegal_op_reset || !periph_clk_en;
  endproperty
  property p_deep;
    !core_power_on |-> !converter_on && !cpu_clk_en && pin_latch;
  endproperty
  property p_por;
    por_restart |-> pin_latch ##[0:1] vector_fetch;
  endproperty
  property p_dbgclk;
    !periph_clk_en && debug_clk_en |-> core_power_on;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector fetch");
  a_nonint: assert property (p_nonint) else $error("command refused");
  a_actv: assert property (p_actv) else $error("command taken");
  a_wait: assert property (p_wait) else $error("bad wait clocks");
  a_irq: assert property (p_irq) else $error("no stacking");
  a_waitcmd: assert property (p_waitcmd) else $error("taken in wait");
  a_stat: assert property (p_stat) else $error("no status error");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_deep: assert property (p_deep) else $error("deep stop power");
  a_por: assert property (p_por) else $error("bad restart");
  a_dbgclk: assert property (p_dbgclk) else $error("deep with debug");
endmodule : opmc_checker
////////////////////////////////////////////////////////////////////////
bind opmc_top opmc_checker u_chk (.pclk, .presetn, .debug_mode_select_pin, .wait_instr,
  .stop_instr, .irq_req, .cmd_valid, .cmd_code, .cmd_accept, .cmd_reject, .cmd_status_err,
  .cpu_clk_en, .periph_clk_en, .debug_clk_en, .regulator_full, .core_power_on, .converter_on,
  .pin_latch, .clear_int_mask, .irq_stack_start, .vector_fetch, .illegal_op_reset,
  .por_restart);

//--- tb/opmc_dbg_host.sv
/* opmc_dbg_host: debug host issuing decoded commands.
   Assumes send is called just after a rising pclk edge. */
module opmc_dbg_host (
  input  wire logic pclk,
  output logic      cmd_valid,
  output logic [2:0] cmd_code
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 3'h7;
  end
  task automatic send(input logic [2:0] c);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c; // stale code must not pass for a fresh one
  endtask : send
endmodule : opmc_dbg_host

//--- tb/operating_mode_controller_tb.sv
/* operating_mode_controller_tb: directed test of opmc_top.
   Assumes opmc_checker is bound and opmc_dbg_host models the host. */
module operating_mode_controller_tb
  import opmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, se, cmd_valid, cmd_accept, cmd_reject, cmd_status_err;
  logic [2:0]  cmd_code;
  logic        cpu_clk_en, periph_clk_en, debug_clk_en, core_power_on, osc_run, pin_latch;
  logic        clear_int_mask, irq_stack_start, vector_fetch, illegal_op_reset, por_restart;
  logic [15:0] vector_addr;
  logic [6:0]  ev = 7'h00;
  logic        ms = 1'b1, wt;
  int          miscompares = 0, n_tests = 0;
  always #4 pclk = ~pclk;
  opmc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .debug_mode_select_pin(ms), .wait_instr(ev[6]), .stop_instr(ev[5]),
    .debug_halt_instruction(ev[4]), .serial_debug_bkpt(ev[3]), .trace_bkpt(ev[2]),
    .irq_req(ev[1]), .wake_req(ev[0]), .cmd_valid, .cmd_code, .cmd_accept, .cmd_reject,
    .cmd_status_err, .cpu_clk_en, .periph_clk_en, .debug_clk_en, .regulator_full(),
    .core_power_on, .osc_run, .converter_on(), .wake_timer_on(wt), .pin_latch, .clear_int_mask,
    .irq_stack_start, .vector_fetch, .vector_addr, .illegal_op_reset, .por_restart);
  opmc_dbg_host u_host (.pclk, .cmd_valid, .cmd_code);
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rchk
  task automatic cmd(input logic [2:0] c, input logic [2:0] e);
    u_host.send(c);
    #1;
    chk(32'({cmd_accept, cmd_reject, cmd_status_err}), 32'(e));
    @(posedge pclk);
  endtask : cmd
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic fire(input int i, input logic [4:0] m, input logic [4:0] e);
    pulse(i);
    #1;
    chk(32'({clear_int_mask, irq_stack_start, vector_fetch, illegal_op_reset, por_restart} & m),
        32'(e));
    @(posedge pclk);
  endtask : fire
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(vector_addr), 32'hfffe);
    rchk(8'h08, 32'h3f, 32'h1);
    rchk(8'h00, 32'h7f, 32'h0);
    rchk(8'h04, 32'h7, 32'h0);
    rchk(8'h0c, 32'hffffffff, 32'h0);
    chk(32'(se), 32'h1);
    for (int c = 0; c < 3; c++) cmd(3'(c), 3'b100);
    for (int c = 4; c < 7; c++) cmd(3'(c), 3'b010);
    cmd(3'h3, 3'b100);
    rchk(8'h08, 32'h1f, 32'h2);
    chk(32'(cpu_clk_en), 32'h0);
    for (int c = 0; c < 7; c++) cmd(3'(c), 3'b100);
    for (int i = 2; i < 5; i++) begin
      fire(i, 5'h1f, 5'h00);
      rchk(8'h08, 32'h1f, 32'h2);
      cmd(3'h6, 3'b100);
    end
    pulse(6);
    cmd(3'h1, 3'b101);
    rchk(8'h08, 32'h1f, 32'h4);
    fire(1, 5'h08, 5'h08);
    pulse(6);
    cmd(3'h0, 3'b010);
    cmd(3'h3, 3'b100);
    rchk(8'h08, 32'h1f, 32'h2);
    cmd(3'h6, 3'b100);
    fire(6, 5'h10, 5'h10);
    fire(1, 5'h08, 5'h08);
    fire(5, 5'h02, 5'h02);
    rchk(8'h08, 32'h1f, 32'h1);
    apb(1'b1, 8'h00, 32'h11);
    fire(5, 5'h02, 5'h00);
    rchk(8'h08, 32'h1f, 32'h8);
    chk(32'({osc_run, cpu_clk_en, periph_clk_en}), 32'h4);
    fire(1, 5'h00, 5'h00);
    apb(1'b1, 8'h04, 32'h1);
    fire(5, 5'h02, 5'h00);
    rchk(8'h08, 32'h3f, 32'h30);
    chk(32'(core_power_on), 32'h0);
    fire(0, 5'h01, 5'h01);
    rchk(8'h04, 32'h2, 32'h2);
    chk(32'(pin_latch), 32'h1);
    apb(1'b1, 8'h04, 32'h5);
    rchk(8'h04, 32'h2, 32'h0);
    chk(32'(pin_latch), 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    fire(5, 5'h02, 5'h00);
    rchk(8'h08, 32'h1f, 32'h8);
    chk(32'(debug_clk_en), 32'h1);
    cmd(3'h3, 3'b100);
    rchk(8'h08, 32'h1f, 32'h2);
    cmd(3'h6, 3'b100);
    apb(1'b1, 8'h00, 32'h4d);
    fire(5, 5'h02, 5'h00);
    rchk(8'h08, 32'h1f, 32'h8);
    chk(32'(wt), 32'h1);
    fire(1, 5'h00, 5'h00);
    // second reset with the mode pin held low must boot into debug
    ms      <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(vector_fetch), 32'h0);
    rchk(8'h08, 32'h1f, 32'h2);
    chk(32'(cpu_clk_en), 32'h0);
    test_done();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule : operating_mode_controller_tb
